// ===== rtl/iass_pkg.sv
// Package for the acknowledge/stop sequencer of the serial port.
// Assumes a single aclk domain and an AXI4-Lite register master.
package iass_pkg;

  localparam int unsigned CLK_HZ = 125000000;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_BAUD   = 8'h0c;
  localparam logic [7:0] OFF_TXBUF  = 8'h10;

  // Control register bit positions
  localparam int CTRL_ACK_EN  = 0;
  localparam int CTRL_ACK_DT  = 1;
  localparam int CTRL_STOP_EN = 2;

  // Status register bit positions (sticky, write one to clear)
  localparam int ST_IRQ  = 0;
  localparam int ST_STOP = 1;
  localparam int ST_WRITE_COLLISION_FLAG = 2;
  localparam int ST_BITS = 3;

  // Reset values
  localparam logic [7:0]  BAUD_RST  = 8'h04;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [7:0] {
    SQ_IDLE     = 8'b0000_0001,
    SQ_ACK_LOW  = 8'b0000_0010,
    SQ_ACK_WAIT = 8'b0000_0100,
    SQ_ACK_HIGH = 8'b0000_1000,
    SQ_STP_SDA  = 8'b0001_0000,
    SQ_STP_LOW  = 8'b0010_0000,
    SQ_STP_SCLH = 8'b0100_0000,
    SQ_STP_DONE = 8'b1000_0000
  } iass_state_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } iass_pins_t;

  typedef struct packed {
    logic ack_go;
    logic ack_dt;
    logic stop_go;
  } iass_cmd_t;

endpackage : iass_pkg

// ===== rtl/iass_baud.sv
// Baud period counter: reload on request, pulse on count reaching zero.
// Assumes period register is stable while a count runs.
`timescale 1ns/1ps
`default_nettype none
module iass_baud (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       reload,
  input  wire logic [7:0] period,
  output var  logic       tick
);
  import iass_pkg::*;

  logic [7:0] cnt_r;
  wire        at_zero = (cnt_r == 8'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || reload) begin
      cnt_r <= period;
    end else if (at_zero) begin
      cnt_r <= period;
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  assign tick = run && !reload && at_zero;
endmodule : iass_baud
`default_nettype wire

// ===== rtl/iass_regs.sv
// AXI4-Lite slave: decodes accesses into strobes, returns read data.
// Assumes one read and one write outstanding at most.
`timescale 1ns/1ps
`default_nettype none
module iass_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output var  logic        s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output var  logic        s_wready,
  output var  logic [1:0]  s_bresp,
  output var  logic        s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output var  logic        s_arready,
  output var  logic [31:0] s_rdata,
  output var  logic [1:0]  s_rresp,
  output var  logic        s_rvalid,
  input  wire logic        s_rready,
  input  wire logic [31:0] rd_value,
  input  wire logic        rd_hit,
  output var  logic [7:0]  rd_addr,
  output var  logic        wr_stb,
  output var  logic [7:0]  wr_addr,
  output var  logic [31:0] wr_data,
  input  wire logic        wr_hit
);
  import iass_pkg::*;

  logic        aw_ok_r, w_ok_r;
  logic [7:0]  awa_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic [7:0]  ara_r;
  logic        ar_ok_r;

  // Low byte lane must be enabled for a write to take effect
  assign wr_stb    = aw_ok_r && w_ok_r && !s_bvalid && ws_r[0];
  assign wr_addr   = awa_r;
  assign wr_data   = wd_r;
  assign rd_addr   = ara_r;
  assign s_awready = !aw_ok_r && !s_bvalid;
  assign s_wready  = !w_ok_r && !s_bvalid;
  assign s_arready = !ar_ok_r && !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r  <= 1'b0;
      w_ok_r   <= 1'b0;
      awa_r    <= 8'h00;
      wd_r     <= 32'h0000_0000;
      ws_r     <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_ok_r <= 1'b1;
        awa_r   <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_ok_r <= 1'b1;
        wd_r   <= s_wdata;
        ws_r   <= s_wstrb;
      end
      if (aw_ok_r && w_ok_r && !s_bvalid) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        aw_ok_r  <= 1'b0;
        w_ok_r   <= 1'b0;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_ok_r  <= 1'b0;
      ara_r    <= 8'h00;
      s_rvalid <= 1'b0;
      s_rdata  <= RD_ZERO;
      s_rresp  <= RESP_OKAY;
    end else begin
      if (s_arvalid && s_arready) begin
        ar_ok_r <= 1'b1;
        ara_r   <= s_araddr;
      end else if (ar_ok_r) begin
        ar_ok_r  <= 1'b0;
        s_rvalid <= 1'b1;
        s_rdata  <= rd_hit ? rd_value : RD_ZERO;
        s_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule : iass_regs
`default_nettype wire

// ===== rtl/iass_top.sv
// Acknowledge and stop sequencer of a two-wire serial port master.
// Assumes SCL/SDA are open drain, sampled synchronously to aclk.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Setting ack enable starts an acknowledge sequence.
// - Ack start pulls SCL low and puts ack data value on SDA.
// - After one baud period SCL is released high.
// - Wait for SCL sampled high, count one period, pull SCL low.
// - At end clear ack enable, stop baud counter, go idle.
// - Buffer write during ack sets collision flag; buffer unchanged.
// - Stop enable makes a stop condition after receive or transmit.
// - SCL held low after the ninth clock falling edge.
// - Stop drives SDA low; once sampled low, reload and count down.
// - On timeout release SCL; one period later release SDA.
// - Stop detected flag set when SDA and SCL both sampled high.
// - One period after stop detect clear stop enable, set irq flag.
// - Buffer write during stop sets collision flag; buffer unchanged.
module iass_top
  import iass_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_i,
  output var  logic        scl_o,
  output var  logic        scl_oe,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe,
  output var  logic        irq
);
  import iass_pkg::*;

  iass_state_t state_r, state_nxt;
  iass_pins_t  pins_r, pins_nxt;
  logic [2:0]  ctrl_r;
  logic [ST_BITS-1:0] status_r, mask_r;
  logic [7:0]  baud_r;
  logic [7:0]  txbuf_r;
  logic        irq_r;

  logic [7:0]  rd_addr, wr_addr;
  logic [31:0] wr_data;
  logic        wr_stb;
  logic        tick;

  // One decode serves both channels, so the two maps cannot drift apart
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_MASK) ||
                 (a == OFF_BAUD) || (a == OFF_TXBUF);
  endfunction : reg_mapped

  wire seq_busy   = (state_r != SQ_IDLE);
  wire ctrl_wr    = wr_stb && (wr_addr == OFF_CTRL);
  wire status_wr  = wr_stb && (wr_addr == OFF_STATUS);
  wire mask_wr    = wr_stb && (wr_addr == OFF_MASK);
  wire baud_wr    = wr_stb && (wr_addr == OFF_BAUD);
  wire txbuf_wr   = wr_stb && (wr_addr == OFF_TXBUF);
  wire write_collision_flag_ev    = txbuf_wr && seq_busy;
  // Response depends on the address only; a masked lane still answers OKAY
  wire wr_hit     = reg_mapped(wr_addr);
  wire rd_hit     = reg_mapped(rd_addr);
  wire ack_start  = (state_r == SQ_IDLE) && ctrl_r[CTRL_ACK_EN];
  wire stop_start = (state_r == SQ_IDLE) && !ctrl_r[CTRL_ACK_EN] &&
                    ctrl_r[CTRL_STOP_EN];
  wire ack_done   = (state_r == SQ_ACK_HIGH) && tick;
  wire stop_det   = (state_r == SQ_STP_SCLH) && !pins_r.sda_oe &&
                    sda_i && scl_i;
  wire stop_end   = (state_r == SQ_STP_DONE) && tick;
  // Reload at stop detect so the closing delay is a full period
  wire baud_reload = (state_r == SQ_ACK_WAIT) ||
                     (state_r == SQ_STP_SDA) ||
                     stop_det;

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h00_0000, v};
  endfunction : zext8

  wire [31:0] rd_value =
    (rd_addr == OFF_CTRL)   ? {29'h0, ctrl_r} :
    (rd_addr == OFF_STATUS) ? {29'h0, status_r} :
    (rd_addr == OFF_MASK)   ? {29'h0, mask_r} :
    (rd_addr == OFF_BAUD)   ? zext8(baud_r) : zext8(txbuf_r);

  iass_regs u_regs (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_axi_awaddr),
    .s_awvalid (s_axi_awvalid),
    .s_awready (s_axi_awready),
    .s_wdata   (s_axi_wdata),
    .s_wstrb   (s_axi_wstrb),
    .s_wvalid  (s_axi_wvalid),
    .s_wready  (s_axi_wready),
    .s_bresp   (s_axi_bresp),
    .s_bvalid  (s_axi_bvalid),
    .s_bready  (s_axi_bready),
    .s_araddr  (s_axi_araddr),
    .s_arvalid (s_axi_arvalid),
    .s_arready (s_axi_arready),
    .s_rdata   (s_axi_rdata),
    .s_rresp   (s_axi_rresp),
    .s_rvalid  (s_axi_rvalid),
    .s_rready  (s_axi_rready),
    .rd_value  (rd_value),
    .rd_hit    (rd_hit),
    .rd_addr   (rd_addr),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_hit    (wr_hit)
  );

  // Counter runs only while a sequence is under way
  iass_baud u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (seq_busy),
    .reload  (baud_reload),
    .period  (baud_r),
    .tick    (tick)
  );

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    pins_nxt  = pins_r;
    unique case (state_r)
      SQ_IDLE: begin
        if (ack_start) begin
          state_nxt       = SQ_ACK_LOW;
          pins_nxt.scl_oe = 1'b1;
          pins_nxt.sda_oe = !ctrl_r[CTRL_ACK_DT];
        end else if (stop_start) begin
          state_nxt       = SQ_STP_SDA;
          pins_nxt.scl_oe = 1'b1;
          pins_nxt.sda_oe = 1'b1;
        end
      end
      SQ_ACK_LOW: if (tick) begin
        state_nxt       = SQ_ACK_WAIT;
        pins_nxt.scl_oe = 1'b0;
      end
      // Slaves may stretch the clock; wait for the line itself
      SQ_ACK_WAIT: if (scl_i) begin
        state_nxt = SQ_ACK_HIGH;
      end
      SQ_ACK_HIGH: if (tick) begin
        state_nxt       = SQ_IDLE;
        pins_nxt.scl_oe = 1'b1;
        pins_nxt.sda_oe = 1'b0;
      end
      SQ_STP_SDA: if (!sda_i) begin
        state_nxt = SQ_STP_LOW;
      end
      SQ_STP_LOW: if (tick) begin
        state_nxt       = SQ_STP_SCLH;
        pins_nxt.scl_oe = 1'b0;
      end
      SQ_STP_SCLH: begin
        if (tick && pins_r.sda_oe) begin
          pins_nxt.sda_oe = 1'b0;
        end else if (!pins_r.sda_oe && sda_i && scl_i) begin
          state_nxt = SQ_STP_DONE;
        end
      end
      SQ_STP_DONE: if (tick) begin
        state_nxt = SQ_IDLE;
      end
      default: begin
        state_nxt = SQ_IDLE;
        pins_nxt  = '0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SQ_IDLE;
      pins_r  <= '0;
    end else begin
      state_r <= state_nxt;
      pins_r  <= pins_nxt;
    end
  end

  // Control: hardware clears enables at end of its sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 3'b000;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= wr_data[2:0];
      end
      if (ack_done) begin
        ctrl_r[CTRL_ACK_EN] <= 1'b0;
      end
      if (stop_end) begin
        ctrl_r[CTRL_STOP_EN] <= 1'b0;
      end
    end
  end

  // Sticky flags: hardware set wins over a clearing write
  wire [ST_BITS-1:0] st_set = {write_collision_flag_ev, stop_det, stop_end};
  wire [ST_BITS-1:0] st_clr = status_wr ? wr_data[ST_BITS-1:0] : '0;
  wire [ST_BITS-1:0] status_nxt = (status_r & ~st_clr) | st_set;
  wire [ST_BITS-1:0] mask_nxt   = mask_wr ? wr_data[ST_BITS-1:0] : mask_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      mask_r   <= '0;
      baud_r   <= BAUD_RST;
      txbuf_r  <= 8'h00;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      if (baud_wr) begin
        baud_r <= wr_data[7:0];
      end
      if (txbuf_wr && !seq_busy) begin
        txbuf_r <= wr_data[7:0];
      end
      // Next values, so a mask write takes effect without extra lag
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  assign scl_oe = pins_r.scl_oe;
  assign sda_oe = pins_r.sda_oe;
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign irq    = irq_r;

  property p_ack_scl_low;
    @(posedge aclk) disable iff (!aresetn)
      ack_start |=> scl_oe && (sda_oe == !$past(ctrl_r[CTRL_ACK_DT]));
  endproperty
  a_ack_scl_low: assert property (p_ack_scl_low)
    else $error("ack start did not drive pins");

  property p_ack_release;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SQ_ACK_LOW && tick) |=> !scl_oe;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("SCL not released after baud period");

  property p_ack_stretch;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SQ_ACK_WAIT && !scl_i) |=> (state_r == SQ_ACK_WAIT);
  endproperty
  a_ack_stretch: assert property (p_ack_stretch)
    else $error("stretch not honoured");

  property p_ack_end;
    @(posedge aclk) disable iff (!aresetn)
      ack_done |=> !ctrl_r[CTRL_ACK_EN] && state_r == SQ_IDLE && scl_oe;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("ack end not clean");

  property p_write_collision_flag;
    @(posedge aclk) disable iff (!aresetn)
      write_collision_flag_ev |=> status_r[ST_WRITE_COLLISION_FLAG] && txbuf_r == $past(txbuf_r);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("collision not flagged or buffer changed");

  property p_stop_sda;
    @(posedge aclk) disable iff (!aresetn)
      stop_start |=> sda_oe && scl_oe;
  endproperty
  a_stop_sda: assert property (p_stop_sda)
    else $error("stop did not pull SDA low");

  property p_stop_det;
    @(posedge aclk) disable iff (!aresetn)
      stop_det |=> status_r[ST_STOP];
  endproperty
  a_stop_det: assert property (p_stop_det)
    else $error("stop detect flag missing");

  property p_stop_end;
    @(posedge aclk) disable iff (!aresetn)
      stop_end |=> !ctrl_r[CTRL_STOP_EN] && status_r[ST_IRQ];
  endproperty
  a_stop_end: assert property (p_stop_end)
    else $error("stop end not flagged");

  property p_write_collision_flag_sticky;
    @(posedge aclk) disable iff (!aresetn)
      (status_r[ST_WRITE_COLLISION_FLAG] && !(status_wr && wr_data[ST_WRITE_COLLISION_FLAG]))
        |=> status_r[ST_WRITE_COLLISION_FLAG];
  endproperty
  a_write_collision_flag_sticky: assert property (p_write_collision_flag_sticky)
    else $error("collision flag dropped");

  property p_ack_enter;
    @(posedge aclk) disable iff (!aresetn)
      ack_start |=> (state_r == SQ_ACK_LOW);
  endproperty
  a_ack_enter: assert property (p_ack_enter)
    else $error("ack sequence not entered");

  property p_ack_rise;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SQ_ACK_WAIT && scl_i) |=>
        (state_r == SQ_ACK_HIGH) && !scl_oe;
  endproperty
  a_ack_rise: assert property (p_ack_rise)
    else $error("high phase not entered after SCL rose");

  property p_stop_hold;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SQ_STP_SDA || state_r == SQ_STP_LOW) |-> scl_oe;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("SCL not held low before stop");

  property p_stop_scl;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SQ_STP_LOW && tick) |=> !scl_oe && sda_oe;
  endproperty
  a_stop_scl: assert property (p_stop_scl)
    else $error("SCL not released first in stop");

  property p_stop_sda_rel;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SQ_STP_SCLH && tick && pins_r.sda_oe) |=> !sda_oe;
  endproperty
  a_stop_sda_rel: assert property (p_stop_sda_rel)
    else $error("SDA not released one period later");
endmodule : iass_top
`default_nettype wire

// ===== sim/iass_slave_model.sv
// Two-wire slave model: stretches SCL after each falling edge.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module iass_slave_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       scl,
  input  wire logic [7:0] stretch,
  output var  logic       scl_hold
);
  logic       scl_q_r;
  logic [7:0] cnt_r;
  // Hold after the fall, as a slow slave would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q_r <= 1'b1;
      cnt_r   <= 8'h00;
    end else begin
      scl_q_r <= scl;
      if (scl_q_r && !scl)
        cnt_r <= stretch;
      else if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
    end
  end
  assign scl_hold = (cnt_r != 8'h00);
endmodule : iass_slave_model
`default_nettype wire

// ===== sim/tb.sv
// Bench: AXI4-Lite master tasks, ack and stop sequences on the wires.
// Assumes open-drain SCL/SDA with pull-ups and one slave model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iass_pkg::*;
  localparam logic [7:0] BAUD = 8'h06;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, stretch;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, r;
  logic        scl_o, scl_oe, sda_o, sda_oe, scl_hold, scl_w, sda_w;
  int          n_errors, compares, i, n0, nl, nr, lo, hi;
  // Open-drain wires, released lines float high
  assign scl_w = !(scl_oe | scl_hold);
  assign sda_w = !sda_oe;
  iass_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  iass_slave_model slv (.aclk(aclk), .aresetn(aresetn), .scl(scl_w),
    .stretch(stretch), .scl_hold(scl_hold));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    bit ad, wd;
    int t;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (ad && wd && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    if (t == 100) n_errors++;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    bit ad;
    int t;
    ad = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (ad && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (!ad && arready) begin
        ad = 1;
        arvalid <= 1'b0;
      end
    end
    if (t == 100) n_errors++;
  endtask : axr
  task automatic phase(input bit sel, input logic lvl, output int n);
    n = 0;
    while (((sel ? sda_oe : scl_oe) === lvl) && n < 1000) begin
      @(posedge aclk);
      #1;
      n++;
    end
  endtask : phase
  task automatic ack_run(input logic dt, input logic [7:0] s);
    stretch <= s;
    axw(OFF_CTRL, {30'h0, dt, 1'b0});
    fork
      begin
        phase(0, 0, n0);
        chk({31'h0, sda_oe}, {31'h0, !dt});
        phase(0, 1, nl);
        phase(0, 0, nr);
        chk({31'h0, scl_oe}, 32'h1);
      end
      begin
        axw(OFF_CTRL, {30'h0, dt, 1'b1});
        axw(OFF_TXBUF, 32'h0000_00a7);
      end
    join
    lo = (s > BAUD + 1) ? int'(s) : BAUD + 1;
    hi = lo + ((s > 0) ? BAUD + 5 : 3);
    chk(nl, BAUD + 1);
    chk({31'h0, (nr >= lo && nr <= hi)}, 32'h1);
    axr(OFF_CTRL);
    chk(d, {30'h0, dt, 1'b0});
    axr(OFF_STATUS);
    chk(d, 32'h4);
    axr(OFF_TXBUF);
    chk(d, 32'h5a);
  endtask : ack_run
  task automatic stop_run();
    axw(OFF_STATUS, 32'h7);
    axw(OFF_MASK, 32'h1);
    fork
      begin
        phase(0, 1, nl);
        chk({31'h0, sda_oe}, 32'h1);
        phase(1, 1, nr);
        chk({31'h0, (nr >= BAUD && nr <= BAUD + 3)}, 32'h1);
        chk({30'h0, scl_oe, irq}, 32'h0);
        n0 = 0;
        while (irq !== 1'b1 && n0 < 100) begin
          @(posedge aclk);
          #1;
          n0++;
        end
        chk({31'h0, (n0 >= BAUD && n0 <= BAUD + 6)}, 32'h1);
      end
      begin
        axw(OFF_CTRL, 32'h4);
        axw(OFF_TXBUF, 32'h0000_00c3);
      end
    join
    axr(OFF_STATUS);
    chk(d, 32'h7);
    axr(OFF_CTRL);
    chk(d, 32'h0);
    axr(OFF_TXBUF);
    chk(d, 32'h5a);
    axw(OFF_MASK, 32'h0);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    axw(OFF_STATUS, 32'h3);
    axr(OFF_STATUS);
    chk(d, 32'h4);
    axw(OFF_STATUS, 32'h4);
    axr(OFF_STATUS);
    chk(d, 32'h0);
  endtask : stop_run
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    summarize();
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    wdata   = 32'h0;
    wstrb   = 4'hf;
    stretch = 8'h00;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    chk({30'h0, scl_o, sda_o}, 32'h0);
    axr(OFF_CTRL);
    chk(d, RD_ZERO);
    axr(OFF_STATUS);
    chk(d, RD_ZERO);
    axr(OFF_MASK);
    chk(d, RD_ZERO);
    axr(OFF_BAUD);
    chk(d, {24'h0, BAUD_RST});
    axr(8'h40);
    chk(d, RD_ZERO);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axw(8'h40, 32'h1);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axw(OFF_BAUD, {24'h0, BAUD});
    axw(OFF_TXBUF, 32'h5a);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    axr(OFF_TXBUF);
    chk(d, 32'h5a);
    // Low lane off: mapped write answers OKAY but changes nothing
    wstrb <= 4'he;
    axw(OFF_TXBUF, 32'h33);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    wstrb <= 4'hf;
    axr(OFF_TXBUF);
    chk(d, 32'h5a);
    for (i = 0; i < 2; i++) begin
      ack_run(i[0], i[0] ? 8'h0e : 8'h00);
      stop_run();
    end
    // Reset in the middle of an ack sequence
    axw(OFF_CTRL, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, scl_oe}, 32'h1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    axr(OFF_CTRL);
    chk(d, RD_ZERO);
    axr(OFF_BAUD);
    chk(d, {24'h0, BAUD_RST});
    summarize();
  end
endmodule : tb
`default_nettype wire
